// file: core/cfg_defs.svh
// token values, endpoint codes and field lengths for the config agent
`ifndef CFG_DEFS_SVH
`define CFG_DEFS_SVH

// ----------------------------------------------------------------------
// control tokens
// ----------------------------------------------------------------------
`define CFG_TOK_WRITE   8'hc0
`define CFG_TOK_READ    8'hc1
`define CFG_TOK_END     8'h01
`define CFG_TOK_ACK     8'h03
`define CFG_TOK_NACK    8'h04

// ----------------------------------------------------------------------
// endpoint codes in the low half of the destination
// ----------------------------------------------------------------------
`define CFG_EP_TILE     16'hc20c
`define CFG_EP_NODE     16'hc30c

// ----------------------------------------------------------------------
// return field and byte counts (last byte index of each field)
// ----------------------------------------------------------------------
`define CFG_NOREPLY     8'hff
`define CFG_RET_LAST    2'h2
`define CFG_REG_LAST    2'h1
`define CFG_WORD_LAST   2'h3

`endif

// file: core/cfg_pkg.sv
// types shared by the config message agent and its register banks
package cfg_pkg;

  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_RET    = 4'h1,
    S_REG    = 4'h2,
    S_DATA   = 4'h3,
    S_END    = 4'h4,
    S_SKIP   = 4'h5,
    S_TX_HDR = 4'h6,
    S_TX_DAT = 4'h7,
    S_TX_END = 4'h8
  } agent_state_e;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ  = 2'h1,
    OP_BAD   = 2'h2
  } op_kind_e;

endpackage

// file: core/cfg_regs_if.sv
// link between the message agent and the register banks
`timescale 1ns/1ps
`default_nettype none

interface cfg_regs_if;
  logic        wr_en;
  logic        bank;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;

  modport agent (output wr_en, bank, addr, wdata, input rdata, hit);
  modport regs  (input wr_en, bank, addr, wdata, output rdata, hit);
endinterface

`default_nettype wire

// file: core/cfg_regfile.sv
// tile and node configuration register banks
`timescale 1ns/1ps
`default_nettype none

module cfg_regfile
  import cfg_pkg::*;
#(
  parameter int NREGS = 8
) (
  input  wire logic clk,    // system clock
  input  wire logic resetn, // async reset, active low
  cfg_regs_if.regs  rb      // access from the agent
);

  localparam int IW = (NREGS > 1) ? $clog2(NREGS) : 1;

  logic [31:0] mem_reg  [0:1][0:NREGS-1];
  logic [31:0] mem_next [0:1][0:NREGS-1];
  logic [IW-1:0] idx;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // numbers past the bank size are unimplemented and never stored
  assign rb.hit   = ({16'h0000, rb.addr} < NREGS);
  assign idx      = rb.addr[IW-1:0];
  assign rb.rdata = rb.hit ? mem_reg[rb.bank][idx] : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // storage, one generated word per bank entry
  // ----------------------------------------------------------------------
  for (genvar b = 0; b < 2; b++) begin : g_bank
    for (genvar i = 0; i < NREGS; i++) begin : g_word
      // word loads only on a committed write aimed at it
      always_comb begin
        mem_next[b][i] = mem_reg[b][i];
        if (rb.wr_en && rb.hit && (rb.bank == 1'(b)) &&
            (idx == IW'(i))) begin
          mem_next[b][i] = rb.wdata;
        end
      end

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          mem_reg[b][i] <= 32'h0000_0000;
        end else begin
          mem_reg[b][i] <= mem_next[b][i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: core/cfg_msg_agent.sv
// token message agent for tile and node configuration registers
//
// Behaviour
// RQ1 - every request carries the top 24 bits of the reply channel end.
// RQ2 - a write whose return field ends in byte ff gets no reply at all.
// RQ3 - multi-byte fields travel most significant byte first both ways.
// RQ4 - processor-status ids are register number shifted by 8 ored with 0b.
// RQ5 - destination nnnnc20c with our tile id reaches the tile bank.
// RQ6 - destination nnnnc30c with our node id reaches the node bank.
// RQ7 - a write is token 192, 24-bit return, 16-bit number, word, token 1.
// RQ8 - a replied write answers 3,1 on success or 4,1 on failure.
// RQ9 - a read is token 192+1, 24-bit return, 16-bit number, token 1.
// RQ10 - a read answers 3, the word, 1 on success or 4,1 on failure.
// RQ11 - the node bank takes the same formats and gives the same answers.
// RQ12 - bad number, bad start token or missing end fails, nothing stored.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defs.svh"

module cfg_msg_agent
  import cfg_pkg::*;
#(
  parameter int NREGS = 8
) (
  input  wire logic        clk,          // system clock, 200 MHz
  input  wire logic        resetn,       // async reset, active low
  input  wire logic [15:0] tile_id,      // our tile identifier
  input  wire logic [15:0] node_id,      // our node identifier
  input  wire logic        rx_valid,     // request token present
  input  wire logic        rx_ctrl,      // token is a control token
  input  wire logic [7:0]  rx_data,      // token value
  input  wire logic [31:0] rx_dest,      // destination, with first token
  output logic             rx_ready,     // agent takes a token
  output logic             tx_valid,     // reply token present
  output logic             tx_ctrl,      // reply token is control
  output logic [7:0]       tx_data,      // reply token value
  output logic [23:0]      tx_return_id, // channel end of the reply
  input  wire logic        tx_ready      // interconnect takes reply token
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  agent_state_e state_reg, state_next;
  op_kind_e     op_reg,    op_next;
  logic [1:0]   cnt_reg,   cnt_next;
  logic         bank_reg,  bank_next;
  logic         fail_reg,  fail_next;
  logic [23:0]  ret_reg,   ret_next;
  logic [15:0]  addr_reg,  addr_next;
  logic [31:0]  data_reg,  data_next;
  logic         rx_ready_reg, rx_ready_next;
  logic         tx_valid_reg, tx_valid_next;
  logic         tx_ctrl_reg,  tx_ctrl_next;
  logic [7:0]   tx_data_reg,  tx_data_next;

  logic acc;
  logic tx_go;
  logic finish;
  logic commit;
  logic is_end;

  cfg_regs_if regs_if ();

  assign acc    = rx_valid & rx_ready_reg;
  assign tx_go  = tx_valid_reg & tx_ready;
  assign is_end = rx_ctrl && (rx_data == `CFG_TOK_END);

  // ----------------------------------------------------------------------
  // register bank access
  // ----------------------------------------------------------------------
  // address and data come from flops, so the bank sees stable fields
  assign regs_if.wr_en = commit;
  assign regs_if.bank  = bank_reg;
  assign regs_if.addr  = addr_reg;
  assign regs_if.wdata = data_reg;

  cfg_regfile #(
    .NREGS (NREGS)
  ) u_regs (
    .clk    (clk),
    .resetn (resetn),
    .rb     (regs_if.regs)
  );

  // ----------------------------------------------------------------------
  // parser and reply sequencer
  // ----------------------------------------------------------------------
  // one process walks the request fields and then the reply tokens
  always_comb begin
    state_next    = state_reg;
    op_next       = op_reg;
    cnt_next      = cnt_reg;
    bank_next     = bank_reg;
    fail_next     = fail_reg;
    ret_next      = ret_reg;
    addr_next     = addr_reg;
    data_next     = data_reg;
    tx_valid_next = tx_valid_reg;
    tx_ctrl_next  = tx_ctrl_reg;
    tx_data_next  = tx_data_reg;
    finish        = 1'b0;
    commit        = 1'b0;
    case (state_reg)
      S_IDLE: begin
        // plain data tokens between messages are dropped
        if (acc && rx_ctrl) begin
          fail_next = 1'b0;
          cnt_next  = 2'h0;
          ret_next  = 24'h00_0000;
          addr_next = 16'h0000;
          state_next = S_RET;
          if (rx_data == `CFG_TOK_WRITE) begin
            op_next = OP_WRITE; // RQ7
          end else if (rx_data == `CFG_TOK_READ) begin
            op_next = OP_READ; // RQ9
          end else begin
            op_next   = OP_BAD; // RQ12
            fail_next = 1'b1;
          end
          if ((rx_dest[15:0] == `CFG_EP_TILE) &&
              (rx_dest[31:16] == tile_id)) begin
            bank_next = 1'b0; // RQ5
          end else if ((rx_dest[15:0] == `CFG_EP_NODE) &&
                       (rx_dest[31:16] == node_id)) begin
            bank_next = 1'b1; // RQ6 RQ11
          end else begin
            bank_next = 1'b0;
            fail_next = 1'b1;
          end
        end
      end
      S_RET: begin
        if (acc) begin
          if (rx_ctrl) begin
            fail_next = 1'b1; // RQ12
            finish    = 1'b1;
          end else begin
            ret_next = {ret_reg[15:0], rx_data}; // RQ1 RQ3
            cnt_next = cnt_reg + 2'h1;
            if (cnt_reg == `CFG_RET_LAST) begin
              cnt_next   = 2'h0;
              state_next = (op_reg == OP_BAD) ? S_SKIP : S_REG;
            end
          end
        end
      end
      S_REG: begin
        if (acc) begin
          if (rx_ctrl) begin
            fail_next = 1'b1; // RQ12
            finish    = 1'b1;
          end else begin
            addr_next = {addr_reg[7:0], rx_data}; // RQ3
            cnt_next  = cnt_reg + 2'h1;
            if (cnt_reg == `CFG_REG_LAST) begin
              cnt_next   = 2'h0;
              state_next = (op_reg == OP_READ) ? S_END : S_DATA; // RQ9
            end
          end
        end
      end
      S_DATA: begin
        if (acc) begin
          if (rx_ctrl) begin
            fail_next = 1'b1; // RQ12
            finish    = 1'b1;
          end else begin
            data_next = {data_reg[23:0], rx_data}; // RQ3 RQ7
            cnt_next  = cnt_reg + 2'h1;
            if (cnt_reg == `CFG_WORD_LAST) begin
              cnt_next   = 2'h0;
              state_next = S_END;
            end
          end
        end
      end
      S_END: begin
        // the store happens only with the closing token and a valid number
        if (acc) begin
          finish = 1'b1;
          if (!is_end || !regs_if.hit) begin
            fail_next = 1'b1; // RQ12
          end else if (!fail_reg) begin
            commit = (op_reg == OP_WRITE); // RQ7 RQ11
            if (op_reg == OP_READ) begin
              data_next = regs_if.rdata; // RQ10
            end
          end
        end
      end
      S_SKIP: begin
        // unknown request: wait for its end, then answer failure
        if (acc && is_end) begin
          finish = 1'b1; // RQ12
        end
      end
      S_TX_HDR: begin
        if (tx_go) begin
          tx_ctrl_next = 1'b1;
          tx_data_next = `CFG_TOK_END;
          state_next   = S_TX_END;
          if ((op_reg == OP_READ) && !fail_reg) begin
            tx_ctrl_next = 1'b0; // RQ10
            tx_data_next = data_reg[31:24]; // RQ3
            data_next    = {data_reg[23:0], 8'h00};
            cnt_next     = 2'h0;
            state_next   = S_TX_DAT;
          end
        end
      end
      S_TX_DAT: begin
        if (tx_go) begin
          cnt_next = cnt_reg + 2'h1;
          if (cnt_reg == `CFG_WORD_LAST) begin
            tx_ctrl_next = 1'b1; // RQ10
            tx_data_next = `CFG_TOK_END;
            state_next   = S_TX_END;
          end else begin
            tx_data_next = data_reg[31:24]; // RQ3
            data_next    = {data_reg[23:0], 8'h00};
          end
        end
      end
      S_TX_END: begin
        if (tx_go) begin
          tx_valid_next = 1'b0;
          tx_ctrl_next  = 1'b0;
          tx_data_next  = 8'h00;
          state_next    = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    // a finished request either goes quiet or opens its reply
    if (finish) begin
      if ((op_reg == OP_WRITE) && (ret_next[7:0] == `CFG_NOREPLY)) begin
        state_next = S_IDLE; // RQ2
      end else begin
        tx_valid_next = 1'b1;
        tx_ctrl_next  = 1'b1;
        tx_data_next  = fail_next ? `CFG_TOK_NACK : `CFG_TOK_ACK; // RQ8 RQ10
        state_next    = S_TX_HDR;
      end
    end
    // no new tokens are taken while a reply is out, which keeps it simple
    rx_ready_next = !((state_next == S_TX_HDR) || (state_next == S_TX_DAT) ||
                      (state_next == S_TX_END));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= S_IDLE;
      op_reg       <= OP_WRITE;
      cnt_reg      <= 2'h0;
      bank_reg     <= 1'b0;
      fail_reg     <= 1'b0;
      ret_reg      <= 24'h00_0000;
      addr_reg     <= 16'h0000;
      data_reg     <= 32'h0000_0000;
      rx_ready_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_ctrl_reg  <= 1'b0;
      tx_data_reg  <= 8'h00;
    end else begin
      state_reg    <= state_next;
      op_reg       <= op_next;
      cnt_reg      <= cnt_next;
      bank_reg     <= bank_next;
      fail_reg     <= fail_next;
      ret_reg      <= ret_next;
      addr_reg     <= addr_next;
      data_reg     <= data_next;
      rx_ready_reg <= rx_ready_next;
      tx_valid_reg <= tx_valid_next;
      tx_ctrl_reg  <= tx_ctrl_next;
      tx_data_reg  <= tx_data_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rx_ready     = rx_ready_reg;
  assign tx_valid     = tx_valid_reg;
  assign tx_ctrl      = tx_ctrl_reg;
  assign tx_data      = tx_data_reg;
  assign tx_return_id = ret_reg; // RQ1

endmodule

`default_nettype wire

// file: testbench/cfg_msg_agent_asserts.sv
// port checks for the config message agent
`timescale 1ns/1ps
`default_nettype none

module cfg_msg_agent_asserts (
  input wire logic        clk,          // clock
  input wire logic        resetn,       // reset, active low
  input wire logic        rx_valid,     // token offered
  input wire logic        rx_ctrl,      // control flag
  input wire logic [7:0]  rx_data,      // token value
  input wire logic        rx_ready,     // token taken
  input wire logic        tx_valid,     // reply token
  input wire logic        tx_ctrl,      // reply control flag
  input wire logic [7:0]  tx_data,      // reply value
  input wire logic [23:0] tx_return_id, // reply channel end
  input wire logic        tx_ready      // reply taken
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic tk = rx_valid && rx_ready;
  wire logic ak = tx_valid && tx_ready;
  // --------
  // request shapes
  // --------
  sequence s_byte;
    tk && !rx_ctrl;
  endsequence
  sequence s_end;
    tk && rx_ctrl && rx_data == 8'h01;
  endsequence
  // only back-to-back takes match, so a refused token cannot fake one
  sequence s_read;
    tk && rx_ctrl && rx_data == 8'hc1 ##1 s_byte [*5] ##1 s_end;
  endsequence
  // the third return byte must not be ff, or the write is a silent one
  sequence s_write;
    tk && rx_ctrl && rx_data == 8'hc0 ##1 s_byte [*2]
      ##1 (tk && !rx_ctrl && rx_data != 8'hff) ##1 s_byte [*6] ##1 s_end;
  endsequence
  a_read_reply: assert property (s_read |=> tx_valid && tx_ctrl &&
    (tx_data == 8'h03 || tx_data == 8'h04)) else $error("read unanswered");
  a_write_reply: assert property (s_write |=> tx_valid && tx_ctrl)
    else $error("write unanswered");
  a_reply_head: assert property ($rose(tx_valid) |-> tx_ctrl &&
    tx_data inside {8'h03, 8'h04}) else $error("bad first reply token");
  a_fail_close: assert property (ak && tx_ctrl && tx_data == 8'h04
    |=> tx_valid && tx_ctrl && tx_data == 8'h01) else $error("no close");
  a_reply_hold: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_data) && $stable(tx_ctrl)) else $error("reply dropped");
  a_no_rx_reply: assert property (tx_valid |-> !rx_ready)
    else $error("request taken during reply");
  a_close_free: assert property (ak && tx_ctrl && tx_data == 8'h01
    |=> !tx_valid && rx_ready) else $error("no return to idle");
  a_ret_steady: assert property (tx_valid |=> $stable(tx_return_id))
    else $error("return id moved");
endmodule

bind cfg_msg_agent cfg_msg_agent_asserts u_chk (
  .clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_ctrl(rx_ctrl),
  .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_ctrl(tx_ctrl), .tx_data(tx_data), .tx_return_id(tx_return_id),
  .tx_ready(tx_ready)
);

`default_nettype wire

// file: testbench/cfg_requester.sv
// requesting channel end: sends messages, collects replies
`timescale 1ns/1ps
`default_nettype none

module cfg_requester (
  input  wire logic        clk,      // clock
  input  wire logic        rx_ready, // agent takes token
  input  wire logic        tx_valid, // reply token present
  input  wire logic        tx_ctrl,  // reply control flag
  input  wire logic [7:0]  tx_data,  // reply value
  output logic             rx_valid, // token offered
  output logic             rx_ctrl,  // control flag
  output logic [7:0]       rx_data,  // token value
  output logic [31:0]      rx_dest,  // destination
  output logic             tx_ready  // reply accepted
);
  logic [8:0] got[$];
  logic       slow;
  initial begin
    {rx_valid, rx_ctrl, rx_data, rx_dest, tx_ready, slow} = '0;
  end
  // one token, held until the agent is seen ready
  task automatic put(input logic c, input logic [7:0] d);
    rx_valid <= 1'b1;
    rx_ctrl <= c;
    rx_data <= d;
    do @(posedge clk); while (!rx_ready);
  endtask
  // processor-status resource id for a status register number
  function automatic logic [31:0] ps_id(input logic [15:0] rn);
    return ({16'h0000, rn} << 8) | 32'h0000_000b;
  endfunction
  // whole message; nb below 4 cuts the data word short
  task automatic msg(input logic [7:0] op, input logic [31:0] dst,
                     input logic [23:0] ret, input logic [15:0] rn,
                     input logic [31:0] wd, input int nb);
    rx_dest <= dst;
    put(1'b1, op);
    rx_dest <= ~dst;
    for (int i = 2; i >= 0; i--) put(1'b0, ret[8*i+:8]);
    for (int i = 1; i >= 0; i--) put(1'b0, rn[8*i+:8]);
    for (int i = 3; i >= 4 - nb; i--) put(1'b0, wd[8*i+:8]);
    put(1'b1, 8'h01);
    // released lines carry junk, never the last token
    rx_valid <= 1'b0;
    rx_ctrl <= ~rx_ctrl;
    rx_data <= ~rx_data;
  endtask
  // reply intake; slow mode stalls every other cycle
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back({tx_ctrl, tx_data});
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule

`default_nettype wire

// file: testbench/cfg_msg_agent_tb_top.sv
// self-checking bench for the config message agent
`timescale 1ns/1ps
`default_nettype none

module cfg_msg_agent_tb_top;
  typedef logic [8:0] tok_q_t[$];
  localparam logic [31:0] tile_dst = 32'h0012c20c;
  localparam logic [31:0] node_dst = 32'h0034c30c;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] tile_id = 16'h0012;
  logic [15:0] node_id = 16'h0034;
  logic        rx_valid, rx_ctrl, rx_ready, tx_valid, tx_ctrl, tx_ready;
  logic [7:0]  rx_data, tx_data;
  logic [31:0] rx_dest;
  logic [23:0] tx_return_id;
  int          miscompares = 0;
  int          n_checks = 0;
  tok_q_t      ok_q = '{9'h103, 9'h101};
  tok_q_t      no_q = '{9'h104, 9'h101};
  tok_q_t      none_q;

  initial begin
    forever #2.5 clk = ~clk;
  end

  cfg_msg_agent dut (
    .clk(clk), .resetn(resetn), .tile_id(tile_id), .node_id(node_id),
    .rx_valid(rx_valid), .rx_ctrl(rx_ctrl), .rx_data(rx_data),
    .rx_dest(rx_dest), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_ctrl(tx_ctrl), .tx_data(tx_data), .tx_return_id(tx_return_id),
    .tx_ready(tx_ready)
  );
  cfg_requester p (
    .clk(clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_ctrl(tx_ctrl), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ctrl(rx_ctrl), .rx_data(rx_data), .rx_dest(rx_dest),
    .tx_ready(tx_ready)
  );

  // --------
  // helpers
  // --------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic tok_q_t rd(input logic [31:0] w);
    return '{9'h103, {1'b0, w[31:24]}, {1'b0, w[23:16]},
             {1'b0, w[15:8]}, {1'b0, w[7:0]}, 9'h101};
  endfunction
  // send, then wait at least 20 cycles so stray replies show up too
  task automatic op(input logic [7:0] code, input logic [31:0] dst,
                    input logic [23:0] ret, input logic [15:0] rn,
                    input logic [31:0] wd, input int nb, input tok_q_t e);
    int n;
    n = 0;
    p.msg(code, dst, ret, rn, wd, nb);
    while ((p.got.size() < e.size() || n < 20) && n < 300) begin
      @(posedge clk);
      if (tx_valid) chk(32'(tx_return_id), 32'(ret));
      n++;
    end
    chk(32'(p.got.size()), 32'(e.size()));
    foreach (e[i]) chk(32'(p.got[i]), 32'(e[i]));
    p.got.delete();
  endtask

  // --------
  // scenarios
  // --------
  task automatic t_tile;
    op(8'hc0, tile_dst, 24'h0a0b0c, 16'h0003, 32'h12345678, 4, ok_q);
    p.slow = 1'b1;
    op(8'hc1, tile_dst, 24'h0a0b0c, 16'h0003, 0, 0, rd(32'h12345678));
    p.slow = 1'b0;
    $display("tile access done");
  endtask
  task automatic t_node;
    op(8'hc0, node_dst, 24'h010203, 16'h0007, 32'hcafe0001, 4, ok_q);
    op(8'hc1, node_dst, 24'h010203, 16'h0007, 0, 0, rd(32'hcafe0001));
    op(8'hc1, tile_dst, 24'h010203, 16'h0007, 0, 0, rd(0));
    $display("node access done");
  endtask
  task automatic t_quiet;
    op(8'hc0, tile_dst, 24'h0a0bff, 16'h0001, 32'h00c0ffee, 4, none_q);
    op(8'hc1, tile_dst, 24'h0a0bff, 16'h0001, 0, 0, rd(32'h00c0ffee));
    $display("silent write done");
  endtask
  // bad number, misroute, unknown start, cut word; reg 3 must survive
  task automatic t_fail;
    op(8'hc1, tile_dst, 24'h000100, 16'h0008, 0, 0, no_q);
    op(8'hc0, node_dst, 24'h000100, 16'h0008, 1, 4, no_q);
    op(8'hc1, 32'h0013c20c, 24'h000100, 16'h0003, 0, 0, no_q);
    op(8'hc2, tile_dst, 24'h000100, 16'h0003, 0, 0, no_q);
    op(8'hc0, tile_dst, 24'h000100, 16'h0003, 32'hdead0000, 2, no_q);
    op(8'hc1, tile_dst, 24'h000100, 16'h0003, 0, 0, rd(32'h12345678));
    chk(p.ps_id(16'h0005), 32'h0000_050b);
    $display("failure cases done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_tile();
    t_node();
    t_quiet();
    t_fail();
    summarize();
  end
  // watchdog: the run needs about 400 cycles, allow some fifty times that
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
endmodule

`default_nettype wire
